// ===== logic/lsi_defs.svh
// Purpose: constants for the light sensor timing and interrupt block
// Assumes: 40 MHz core clock
// Notes: register addresses are the low nibble of the command byte
`ifndef LSI_DEFS_SVH
`define LSI_DEFS_SVH

// command byte fields
`define LSI_CMD_BIT 7
`define LSI_CLR_BIT 6
`define LSI_WORD_BIT 5

// register addresses
`define LSI_ADDR_CTRL 4'h0
`define LSI_ADDR_TIMING 4'h1
`define LSI_ADDR_THLO_L 4'h2
`define LSI_ADDR_THLO_H 4'h3
`define LSI_ADDR_THHI_L 4'h4
`define LSI_ADDR_THHI_H 4'h5
`define LSI_ADDR_INTC 4'h6

// reset values
`define LSI_CMD_RST 8'h00
`define LSI_CTRL_RST 8'h00
`define LSI_TIMING_RST 8'h02
`define LSI_INTC_RST 8'h00
`define LSI_THR_RST 16'h0000

// timing register fields
`define LSI_GAIN_BIT 4
`define LSI_MSTART_BIT 3
`define LSI_TINT_13 2'h0
`define LSI_TINT_101 2'h1
`define LSI_TINT_402 2'h2
`define LSI_TINT_MANUAL 2'h3

// interrupt style codes, bits 5:4; persistence in bits 3:0
`define LSI_STYLE_OFF 2'h0
`define LSI_STYLE_LEVEL 2'h1
`define LSI_STYLE_ALERT 2'h2
`define LSI_STYLE_TEST 2'h3

// integration times and cycle counts
`define LSI_CLK_MHZ 40
`define LSI_TINT0_US 13700
`define LSI_TINT1_US 101000
`define LSI_TINT2_US 402000
`define LSI_TINT0_CYC (`LSI_TINT0_US * `LSI_CLK_MHZ)
`define LSI_TINT1_CYC (`LSI_TINT1_US * `LSI_CLK_MHZ)
`define LSI_TINT2_CYC (`LSI_TINT2_US * `LSI_CLK_MHZ)
`define LSI_TCNT_W 24

`endif

// ===== logic/lsi_pkg.sv
// Purpose: types for the light sensor timing and interrupt block
// Assumes: lsi_defs.svh supplies widths
// Notes: none
`include "lsi_defs.svh"
package lsi_pkg;

  typedef enum logic [2:0] {
    lsi_op_send,
    lsi_op_wbyte,
    lsi_op_wword,
    lsi_op_rbyte,
    lsi_op_rword,
    lsi_op_ara
  } lsi_op_e;

  typedef struct packed {
    lsi_op_e kind;
    logic [7:0] cmd;
    logic [15:0] data;
  } lsi_op_s;

  typedef struct packed {
    logic rq1;
    logic rq2;
    logic rq3;
    logic ack_tgl;
    logic [15:0] rdata;
    logic [7:0] cmd;
    logic [7:0] ctrl;
    logic [7:0] timing;
    logic [15:0] thr_lo;
    logic [15:0] thr_hi;
    logic [7:0] intc;
    logic [3:0] pcnt;
    logic pend;
    logic [`LSI_TCNT_W-1:0] tcnt;
    logic gain_16x;
    logic integrating;
    logic conv_end;
    logic int_o;
    logic int_oe;
  } lsi_core_s;

  typedef struct packed {
    logic rst1;
    logic rst2;
    logic req_tgl;
    lsi_op_s op;
    logic as1;
    logic as2;
    logic as3;
    logic busy;
    logic done;
    logic [15:0] rdata;
  } lsi_link_s;

endpackage

// ===== logic/lsi_light_timing_int.sv
// Purpose: gain, integration timing and threshold interrupt of a
//   dual channel light converter, with a link-clock transaction port
// Assumes: bus framing decodes transactions on link_clk; adc_ch0 is the
//   channel 0 result, valid on clk when conv_end would be raised
// Notes: one transaction in flight; link_busy holds off the next
`timescale 1ns/1ps
`default_nettype none
`include "lsi_defs.svh"

module lsi_light_timing_int #(
  parameter logic [`LSI_TCNT_W-1:0] TINT0_CYC = `LSI_TINT0_CYC,
  parameter logic [`LSI_TCNT_W-1:0] TINT1_CYC = `LSI_TINT1_CYC,
  parameter logic [`LSI_TCNT_W-1:0] TINT2_CYC = `LSI_TINT2_CYC,
  parameter logic [6:0] SLAVE_ADDR = 7'h39
) (
  // core clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link side transactions
  input wire logic link_clk,
  input wire logic link_op_valid,
  input wire lsi_pkg::lsi_op_s link_op,
  output logic link_busy,
  output logic link_done,
  output logic [15:0] link_rdata,
  // converter front end
  input wire logic [15:0] adc_ch0,
  output logic gain_16x,
  output logic integrating,
  output logic conv_end,
  // open drain interrupt pin
  output logic int_o,
  output logic int_oe
);

  localparam lsi_pkg::lsi_core_s CORE_RST = '{
    cmd: `LSI_CMD_RST, ctrl: `LSI_CTRL_RST, timing: `LSI_TIMING_RST,
    thr_lo: `LSI_THR_RST, thr_hi: `LSI_THR_RST, intc: `LSI_INTC_RST,
    integrating: 1'b1, default: '0};

  lsi_pkg::lsi_core_s r;
  lsi_pkg::lsi_core_s next_r;
  lsi_pkg::lsi_link_s l;
  lsi_pkg::lsi_link_s next_l;

  logic op_fire;
  logic wr;
  logic word;
  logic cfg_wr;
  logic tim_wr;
  logic manual;
  logic end_now;
  logic out_rng;
  logic set_evt;
  logic clr_evt;
  logic [3:0] addr;
  logic [3:0] addr_p1;
  logic [3:0] persist;
  logic [1:0] interrupt_style_select;
  logic [`LSI_TCNT_W-1:0] lim;

  function automatic logic [`LSI_TCNT_W-1:0] tint_limit(
      input logic [1:0] code);
    case (code)
      `LSI_TINT_13: tint_limit = TINT0_CYC - 1'b1;
      `LSI_TINT_101: tint_limit = TINT1_CYC - 1'b1;
      default: tint_limit = TINT2_CYC - 1'b1;
    endcase
  endfunction

  function automatic logic [7:0] reg_rd(input lsi_pkg::lsi_core_s s,
      input logic [3:0] ad);
    case (ad)
      `LSI_ADDR_CTRL: reg_rd = s.ctrl;
      `LSI_ADDR_TIMING: reg_rd = s.timing;
      `LSI_ADDR_THLO_L: reg_rd = s.thr_lo[7:0];
      `LSI_ADDR_THLO_H: reg_rd = s.thr_lo[15:8];
      `LSI_ADDR_THHI_L: reg_rd = s.thr_hi[7:0];
      `LSI_ADDR_THHI_H: reg_rd = s.thr_hi[15:8];
      `LSI_ADDR_INTC: reg_rd = s.intc;
      default: reg_rd = 8'h00;
    endcase
  endfunction

  function automatic lsi_pkg::lsi_core_s put_byte(
      input lsi_pkg::lsi_core_s s, input logic [3:0] ad,
      input logic [7:0] v);
    lsi_pkg::lsi_core_s t;
    t = s;
    case (ad)
      `LSI_ADDR_CTRL: t.ctrl = v;
      `LSI_ADDR_TIMING: t.timing = v;
      `LSI_ADDR_THLO_L: t.thr_lo[7:0] = v;
      `LSI_ADDR_THLO_H: t.thr_lo[15:8] = v;
      `LSI_ADDR_THHI_L: t.thr_hi[7:0] = v;
      `LSI_ADDR_THHI_H: t.thr_hi[15:8] = v;
      // reserved bits 7:6 kept at zero
      `LSI_ADDR_INTC: t.intc = {2'h0, v[5:0]};
      default: t = s;
    endcase
    return t;
  endfunction

  // core domain
  always_comb begin
    next_r = r;
    next_r.rq1 = l.req_tgl;
    next_r.rq2 = r.rq1;
    next_r.rq3 = r.rq2;
    // l.op is held stable by the link side until the ack returns
    op_fire = r.rq2 ^ r.rq3;
    addr = l.op.cmd[3:0];
    addr_p1 = 4'(addr + 4'h1);
    word = l.op.kind == lsi_pkg::lsi_op_wword;
    wr = op_fire && l.op.cmd[`LSI_CMD_BIT] &&
         (word || l.op.kind == lsi_pkg::lsi_op_wbyte);
    if (op_fire && l.op.cmd[`LSI_CMD_BIT] &&
        l.op.kind != lsi_pkg::lsi_op_ara) begin
      next_r.cmd = l.op.cmd;
    end
    if (wr) begin
      next_r = put_byte(next_r, addr, l.op.data[7:0]);
      if (word) begin
        next_r = put_byte(next_r, addr_p1, l.op.data[15:8]);
      end
    end
    cfg_wr = wr && (addr == `LSI_ADDR_INTC ||
                    (word && addr_p1 == `LSI_ADDR_INTC));
    tim_wr = wr && (addr == `LSI_ADDR_TIMING ||
                    (word && addr_p1 == `LSI_ADDR_TIMING));

    // conversion timing
    manual = r.timing[1:0] == `LSI_TINT_MANUAL;
    lim = tint_limit(r.timing[1:0]);
    end_now = 1'b0;
    if (manual) begin
      next_r.tcnt = '0;
      // the period ends when the start bit is written back to zero
      end_now = tim_wr && r.timing[`LSI_MSTART_BIT] &&
                !next_r.timing[`LSI_MSTART_BIT] &&
                next_r.timing[1:0] == `LSI_TINT_MANUAL;
    end else if (tim_wr) begin
      next_r.tcnt = '0;
    end else if (r.tcnt >= lim) begin
      next_r.tcnt = '0;
      end_now = 1'b1;
    end else begin
      next_r.tcnt = r.tcnt + 1'b1;
    end

    // threshold and persistence
    interrupt_style_select = r.intc[5:4];
    persist = r.intc[3:0];
    out_rng = adc_ch0 < r.thr_lo || adc_ch0 > r.thr_hi;
    set_evt = 1'b0;
    if (cfg_wr) begin
      next_r.pcnt = 4'h0;
      set_evt = next_r.intc[5:4] == `LSI_STYLE_TEST;
    end else if (end_now) begin
      if (persist == 4'h0) begin
        set_evt = 1'b1;
      end else if (!out_rng) begin
        next_r.pcnt = 4'h0;
      end else begin
        set_evt = {1'b0, r.pcnt} + 5'h01 >= {1'b0, persist};
        if (r.pcnt != 4'hF) begin
          next_r.pcnt = 4'(r.pcnt + 4'h1);
        end
      end
    end
    clr_evt = 1'b0;
    if (op_fire && l.op.kind == lsi_pkg::lsi_op_ara) begin
      clr_evt = interrupt_style_select[1];
    end else if (op_fire && l.op.cmd[`LSI_CMD_BIT] &&
                 l.op.cmd[`LSI_CLR_BIT]) begin
      clr_evt = interrupt_style_select == `LSI_STYLE_LEVEL;
    end
    // a new event in the clearing cycle wins
    if (set_evt) begin
      next_r.pend = 1'b1;
    end else if (clr_evt) begin
      next_r.pend = 1'b0;
    end
    // disabled style drops any stale request so it cannot pop later
    if (next_r.intc[5:4] == `LSI_STYLE_OFF) begin
      next_r.pend = 1'b0;
    end

    // read answers
    if (op_fire) begin
      next_r.ack_tgl = ~r.ack_tgl;
      case (l.op.kind)
        lsi_pkg::lsi_op_rbyte: next_r.rdata = {8'h00, reg_rd(r, addr)};
        lsi_pkg::lsi_op_rword:
          next_r.rdata = {reg_rd(r, addr_p1), reg_rd(r, addr)};
        lsi_pkg::lsi_op_ara:
          // only a device holding alert answers; idle bus reads ones
          next_r.rdata = (r.pend && interrupt_style_select[1]) ?
                         {8'h00, SLAVE_ADDR, 1'b0} : 16'h00FF;
        default: next_r.rdata = 16'h0000;
      endcase
    end

    next_r.gain_16x = next_r.timing[`LSI_GAIN_BIT];
    next_r.integrating =
      (next_r.timing[1:0] == `LSI_TINT_MANUAL) ?
      next_r.timing[`LSI_MSTART_BIT] : 1'b1;
    next_r.conv_end = end_now;
    next_r.int_o = 1'b0;
    next_r.int_oe = next_r.pend &&
                    next_r.intc[5:4] != `LSI_STYLE_OFF;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= CORE_RST;
    end else begin
      r <= next_r;
    end
  end

  // link domain
  always_comb begin
    next_l = l;
    next_l.rst1 = rst_n;
    next_l.rst2 = l.rst1;
    next_l.as1 = r.ack_tgl;
    next_l.as2 = l.as1;
    next_l.as3 = l.as2;
    next_l.done = 1'b0;
    if (!l.rst2) begin
      next_l.req_tgl = 1'b0;
      next_l.op = '0;
      next_l.as2 = 1'b0;
      next_l.as3 = 1'b0;
      next_l.busy = 1'b0;
      next_l.rdata = 16'h0000;
    end else if (l.busy) begin
      if (l.as2 ^ l.as3) begin
        next_l.busy = 1'b0;
        next_l.done = 1'b1;
        next_l.rdata = r.rdata;
      end
    end else if (link_op_valid) begin
      next_l.op = link_op;
      next_l.req_tgl = ~l.req_tgl;
      next_l.busy = 1'b1;
    end
  end

  // reset reaches this domain through two flops; the toggles both
  // restart at zero so the first request is seen as a change
  always_ff @(posedge link_clk) begin
    l <= next_l;
  end

  assign link_busy = l.busy;
  assign link_done = l.done;
  assign link_rdata = l.rdata;
  assign gain_16x = r.gain_16x;
  assign integrating = r.integrating;
  assign conv_end = r.conv_end;
  assign int_o = r.int_o;
  assign int_oe = r.int_oe;

  // checks
  reset_defaults_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> r.timing == 8'h02 && r.intc == 8'h00)
    else $error("registers not at defaults after reset");
  long_tint_a: assert property (@(posedge clk) disable iff (!rst_n)
    end_now && !manual && r.timing[1:0] == 2'h2
    |-> r.tcnt == TINT2_CYC - 1'b1)
    else $error("402 ms period has wrong length");
  gain_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 gain_16x == $past(next_r.timing[4]))
    else $error("gain output does not follow gain bit");
  manual_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
    r.timing[1:0] == 2'h3 && !r.timing[3] |-> !integrating && !end_now)
    else $error("integrating while manual stopped");
  style_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    r.intc[5:4] == 2'h0 |-> !int_oe)
    else $error("interrupt driven while disabled");
  every_conv_a: assert property (@(posedge clk) disable iff (!rst_n)
    end_now && !cfg_wr && persist == 4'h0 && r.intc[5:4] != 2'h0
    |=> int_oe && conv_end)
    else $error("no interrupt at end of conversion");
  first_excursion_a: assert property (@(posedge clk) disable iff (!rst_n)
    end_now && !cfg_wr && persist == 4'h1 && adc_ch0 > r.thr_hi &&
    r.intc[5:4] != 2'h0 |=> int_oe)
    else $error("persist one did not interrupt");
  early_persist_a: assert property (@(posedge clk) disable iff (!rst_n)
    end_now && !op_fire && !r.pend && persist >= 4'h2 &&
    {1'b0, r.pcnt} + 5'h01 < {1'b0, persist} |=> !r.pend)
    else $error("interrupt before persistence count");
  in_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    end_now && persist != 4'h0 && adc_ch0 >= r.thr_lo &&
    adc_ch0 <= r.thr_hi |=> r.pcnt == 4'h0)
    else $error("counter kept after in-range result");
  line_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    int_oe && !clr_evt && !cfg_wr |=> int_oe)
    else $error("interrupt released without clear");
  level_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    op_fire && l.op.cmd[7] && l.op.cmd[6] && r.intc[5:4] == 2'h1 &&
    !set_evt |=> !int_oe)
    else $error("level clear ignored");
  alert_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    op_fire && l.op.kind == lsi_pkg::lsi_op_ara && r.intc[5] &&
    !set_evt |=> !int_oe)
    else $error("alert response did not release line");
  test_force_a: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_wr && next_r.intc[5:4] == 2'h3 |=> int_oe)
    else $error("test code did not force interrupt");
  thr_word_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr && word && l.op.cmd == 8'hA2 |=> r.thr_lo == $past(l.op.data))
    else $error("lower threshold word write wrong");

  test_mode_c: cover property (@(posedge clk) disable iff (!rst_n)
    cfg_wr && next_r.intc == 8'h30 ##1 int_oe);
  persist3_c: cover property (@(posedge clk) disable iff (!rst_n)
    r.intc == 8'h23 && end_now && set_evt);
  ara_clear_c: cover property (@(posedge clk) disable iff (!rst_n)
    int_oe && clr_evt && l.op.kind == lsi_pkg::lsi_op_ara);
  manual_conv_c: cover property (@(posedge clk) disable iff (!rst_n)
    manual && end_now);

endmodule

`default_nettype wire

// ===== sim/lsi_host_model.sv
// Purpose: host end of the link, one transaction at a time
// Assumes: link_busy is low whenever a new request starts
// Notes: the link clock stands still between transactions
`timescale 1ns/1ps
`default_nettype none
module lsi_host_model (
  // link side
  output logic link_clk,
  output logic link_op_valid,
  output lsi_pkg::lsi_op_s link_op,
  input wire logic link_busy,
  input wire logic link_done,
  input wire logic [15:0] link_rdata
);
  logic run;
  initial begin
    link_clk = 1'b0;
    link_op_valid = 1'b0;
    link_op = '0;
    run = 1'b1;
    #7;
    forever begin
      #16;
      link_clk = run ? ~link_clk : 1'b0;
    end
  end
  task automatic xact(input lsi_pkg::lsi_op_s o, output logic [15:0] rd,
                      output logic ok);
    int i;
    ok = 1'b0;
    rd = 16'h0000;
    run = 1'b1;
    @(posedge link_clk);
    link_op_valid <= 1'b1;
    link_op <= o;
    // busy is read after the edge has settled, so the take is really seen
    @(posedge link_clk);
    #1;
    while (link_busy !== 1'b1) begin
      @(posedge link_clk);
      #1;
    end
    link_op_valid <= 1'b0;
    // released bus shows the inverse so a stale value never matches
    link_op <= lsi_pkg::lsi_op_s'(~o);
    for (i = 0; i < 40 && !ok; i++) begin
      @(posedge link_clk);
      #1;
      ok = (link_done === 1'b1);
    end
    rd = link_rdata;
    @(posedge link_clk);
    run = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// Purpose: self-checking bench of the light timing and interrupt block
// Assumes: short integration counts of 20, 40 and 80 cycles
// Notes: rows cover register access, hand tests cover timing and interrupt
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int T0 = 20;
  localparam int T1 = 40;
  localparam int T2 = 80;
  localparam logic [6:0] SA = 7'h2A;
  typedef struct packed {
    lsi_pkg::lsi_op_e k;
    logic [7:0] c;
    logic [15:0] d;
    logic [15:0] e;
  } lsi_row_s;
  logic clk, rst_n, link_clk, link_op_valid, link_busy, link_done;
  lsi_pkg::lsi_op_s link_op;
  logic [15:0] link_rdata, adc_ch0, rd;
  logic gain_16x, integrating, conv_end, int_o, int_oe;
  int n_errors = 0;
  int samples_checked = 0;
  int n_conv = 0;
  int k, n;
  lsi_row_s rows [13];
  logic [7:0] tv [4];
  int tp [4];
  lsi_light_timing_int #(.TINT0_CYC(24'h14), .TINT1_CYC(24'h28),
    .TINT2_CYC(24'h50), .SLAVE_ADDR(SA)) u_dut (.clk(clk), .rst_n(rst_n),
    .link_clk(link_clk), .link_op_valid(link_op_valid), .link_op(link_op),
    .link_busy(link_busy), .link_done(link_done), .link_rdata(link_rdata),
    .adc_ch0(adc_ch0), .gain_16x(gain_16x), .integrating(integrating),
    .conv_end(conv_end), .int_o(int_o), .int_oe(int_oe));
  lsi_host_model u_host (.link_clk(link_clk), .link_op_valid(link_op_valid),
    .link_op(link_op), .link_busy(link_busy), .link_done(link_done),
    .link_rdata(link_rdata));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) if (conv_end === 1'b1) n_conv++;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got,
               exp);
    end
  endtask
  task automatic op(input lsi_pkg::lsi_op_e kd, input logic [7:0] c,
                    input logic [15:0] d);
    lsi_pkg::lsi_op_s o;
    logic ok;
    o.kind = kd;
    o.cmd = c;
    o.data = d;
    u_host.xact(o, rd, ok);
    chk({15'h0000, ok}, 16'h0001, "link answer");
    repeat (2) @(posedge clk);
    #1;
  endtask
  // waits for m conversion ends, returning 1 ns after the last pulse rises, while conv_end is still high
  task automatic conv(input int m);
    int i, j;
    for (j = 0; j < m; j++) begin
      i = 0;
      do begin
        @(posedge clk);
        #1;
        i++;
      end while (conv_end !== 1'b1 && i < 300);
      chk({15'h0000, conv_end}, 16'h0001, "conversion end");
    end
  endtask
  task automatic set_adc(input logic [15:0] v);
    @(posedge clk);
    adc_ch0 <= v;
  endtask
  task automatic finish_test();
    $display("errors %0d, comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    finish_test();
  end
  initial begin
    rows = '{
      '{lsi_pkg::lsi_op_rbyte, 8'h81, 16'h0000, 16'h0002},
      '{lsi_pkg::lsi_op_rbyte, 8'h86, 16'h0000, 16'h0000},
      '{lsi_pkg::lsi_op_rbyte, 8'h80, 16'h0000, 16'h0000},
      '{lsi_pkg::lsi_op_wword, 8'hA2, 16'h1234, 16'h0000},
      '{lsi_pkg::lsi_op_wword, 8'hA4, 16'h5678, 16'h0000},
      '{lsi_pkg::lsi_op_rword, 8'hA2, 16'h0000, 16'h1234},
      '{lsi_pkg::lsi_op_rbyte, 8'h85, 16'h0000, 16'h0056},
      '{lsi_pkg::lsi_op_rword, 8'hA3, 16'h0000, 16'h7812},
      '{lsi_pkg::lsi_op_wbyte, 8'h81, 16'h0011, 16'h0000},
      '{lsi_pkg::lsi_op_rbyte, 8'h81, 16'h0000, 16'h0011},
      '{lsi_pkg::lsi_op_rbyte, 8'h8E, 16'h0000, 16'h0000},
      '{lsi_pkg::lsi_op_wbyte, 8'h02, 16'h00AA, 16'h0000},
      '{lsi_pkg::lsi_op_rbyte, 8'h82, 16'h0000, 16'h0034}};
    tv = '{8'h00, 8'h01, 8'h02, 8'h11};
    tp = '{T0, T1, T2, T1};
    rst_n = 1'b0;
    adc_ch0 = 16'h1800;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk({12'h000, gain_16x, integrating, conv_end, int_oe}, 16'h0004,
        "reset outputs");
    chk({15'h0000, link_busy}, 16'h0000, "reset busy");
    repeat (8) @(posedge clk);
    for (k = 0; k < 13; k++) begin
      op(rows[k].k, rows[k].c, rows[k].d);
      chk(rd, rows[k].e, "register row");
    end
    chk({15'h0000, gain_16x}, 16'h0001, "gain set");
    for (k = 0; k < 4; k++) begin
      op(lsi_pkg::lsi_op_wbyte, 8'h81, {8'h00, tv[k]});
      conv(1);
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (conv_end !== 1'b1 && n < 300);
      chk(n[15:0], tp[k][15:0], "conversion period");
      chk({15'h0000, gain_16x}, {15'h0000, tv[k][4]}, "gain");
    end
    // manual integration, host times the period itself
    op(lsi_pkg::lsi_op_wbyte, 8'h81, 16'h0003);
    n = n_conv;
    repeat (200) @(posedge clk);
    chk(n_conv[15:0], n[15:0], "no auto conversion");
    chk({15'h0000, integrating}, 16'h0000, "manual idle");
    op(lsi_pkg::lsi_op_wbyte, 8'h81, 16'h000B);
    chk({15'h0000, integrating}, 16'h0001, "manual start");
    repeat (50) @(posedge clk);
    op(lsi_pkg::lsi_op_wbyte, 8'h81, 16'h0003);
    chk(n_conv[15:0], n[15:0] + 16'h0001, "manual stop end");
    chk({15'h0000, integrating}, 16'h0000, "manual stopped");
    op(lsi_pkg::lsi_op_wbyte, 8'h86, 16'h0030);
    chk({15'h0000, int_oe}, 16'h0001, "test mode");
    op(lsi_pkg::lsi_op_ara, 8'h00, 16'h0000);
    chk(rd, {8'h00, SA, 1'b0}, "alert answer");
    chk({15'h0000, int_oe}, 16'h0000, "alert cleared");
    op(lsi_pkg::lsi_op_ara, 8'h00, 16'h0000);
    chk(rd, 16'h00FF, "alert none");
    op(lsi_pkg::lsi_op_wbyte, 8'h81, 16'h0002);
    op(lsi_pkg::lsi_op_wword, 8'hA2, 16'h1000);
    op(lsi_pkg::lsi_op_wword, 8'hA4, 16'h2000);
    op(lsi_pkg::lsi_op_wbyte, 8'h86, 16'h0010);
    conv(1);
    chk({15'h0000, int_oe}, 16'h0001, "every conversion");
    op(lsi_pkg::lsi_op_send, 8'hC0, 16'h0000);
    chk({int_o, int_oe}, 2'b00, "level clear");
    op(lsi_pkg::lsi_op_wbyte, 8'h86, 16'h0000);
    conv(2);
    chk({15'h0000, int_oe}, 16'h0000, "disabled");
    op(lsi_pkg::lsi_op_wbyte, 8'h86, 16'h0011);
    conv(1);
    set_adc(16'h1000);
    conv(1);
    set_adc(16'h2000);
    conv(1);
    chk({15'h0000, int_oe}, 16'h0000, "edges in range");
    set_adc(16'h0FFF);
    conv(1);
    chk({15'h0000, int_oe}, 16'h0001, "persist one");
    set_adc(16'h1800);
    conv(1);
    chk({15'h0000, int_oe}, 16'h0001, "held low");
    op(lsi_pkg::lsi_op_send, 8'hC0, 16'h0000);
    op(lsi_pkg::lsi_op_wbyte, 8'h86, 16'h0023);
    conv(1);
    set_adc(16'h2001);
    conv(2);
    set_adc(16'h1800);
    conv(1);
    set_adc(16'h2001);
    conv(2);
    chk({15'h0000, int_oe}, 16'h0000, "run broken");
    conv(1);
    chk({15'h0000, int_oe}, 16'h0001, "persist three");
    op(lsi_pkg::lsi_op_send, 8'hC0, 16'h0000);
    chk({15'h0000, int_oe}, 16'h0001, "alert ignores clear bit");
    op(lsi_pkg::lsi_op_ara, 8'h00, 16'h0000);
    chk({15'h0000, int_oe}, 16'h0000, "alert released");
    finish_test();
  end
endmodule
`default_nettype wire
